// ==== pkg/slpmc_defs.vh ====
// Constants for the sleep mode controller.
// Assumes inclusion by bare name from the rtl files.
`ifndef SLPMC_DEFS_VH
`define SLPMC_DEFS_VH
// ==========================================
// Mode encodings
`define SLPMC_MODE_IDLE 3'h0
`define SLPMC_MODE_PDOWN 3'h2
`define SLPMC_MODE_PSAVE 3'h3
`define SLPMC_MODE_STDBY 3'h6
`define SLPMC_MODE_ESTDBY 3'h7
// ==========================================
// Wake source vector bit positions
`define SLPMC_WK_IRQ 0
`define SLPMC_WK_PINCHG 1
`define SLPMC_WK_TWI_MATCH 2
`define SLPMC_WK_WDT_RST 3
`define SLPMC_WK_WDT_IRQ 4
`define SLPMC_WK_EXT_RST 5
`define SLPMC_WK_RTC_IRQ 6
`define SLPMC_WK_WIDTH 7
// ==========================================
// Controller states
`define SLPMC_ST_ACTIVE 2'h0
`define SLPMC_ST_SLEEP 2'h1
`define SLPMC_ST_WAKE 2'h2
`endif

// ==== rtl/slpmc_top.v ====
// Sleep mode controller: mode register, sleep state machine, clock gates.
// Assumes all inputs synchronous to i_clock; gate outputs drive clock enables.
// Behaviour
// RULE_01 - Sleep is entered only from Active, on software request with chosen mode.
// RULE_02 - A wake source valid for the current mode returns to Active.
// RULE_03 - Idle stops CPU and NVM; peripherals, events and DMA run.
// RULE_04 - Idle wakes on any enabled interrupt request.
// RULE_05 - Power-down stops all clock sources; only clockless logic runs.
// RULE_06 - Power-down wakes on pin change, address match, watchdog, external reset.
// RULE_07 - Power-save keeps enabled real-time counter and its clock running.
// RULE_08 - Power-save accepts Power-down sources plus real-time counter interrupt.
// RULE_09 - Standby is Power-down but oscillators in use keep running.
// RULE_10 - Extended Standby is Power-save plus oscillators in use kept running.
// RULE_11 - Event routing clocked only in Active and Idle.
// RULE_12 - After oscillators stopped, hold CPU until system clock is stable.
// RULE_13 - Software writes mode selection; processor raises sleep request.
`include "slpmc_defs.vh"

module slpmc_top (
	input wire i_clock,
	input wire i_resetn,
	input wire i_mode_we,
	input wire [2:0] i_mode_wdata,
	input wire i_sleep_req,
	input wire i_rtc_enable,
	input wire i_clk_stable,
	input wire i_irq,
	input wire i_pin_change,
	input wire i_twi_match,
	input wire i_wdt_reset,
	input wire i_wdt_irq,
	input wire i_ext_reset,
	input wire i_rtc_irq,
	output reg o_cpu_run,
	output reg o_nvm_clk_en,
	output reg o_periph_clk_en,
	output reg o_event_clk_en,
	output reg o_osc_en,
	output reg o_rtc_clk_en,
	output reg o_sleeping,
	output reg [2:0] o_mode
);
	// ==========================================
	// Mode selection register
	reg [2:0] mode_reg;
	reg valid_mode;
	always @* begin
		case (i_mode_wdata)
			`SLPMC_MODE_IDLE, `SLPMC_MODE_PDOWN, `SLPMC_MODE_PSAVE,
			`SLPMC_MODE_STDBY, `SLPMC_MODE_ESTDBY: valid_mode = 1'b1;
			default: valid_mode = 1'b0;
		endcase
	end
	// ==========================================
	// State machine
	reg [1:0] state_reg;
	reg [1:0] state_next;
	wire wake;
	wire [`SLPMC_WK_WIDTH-1:0] sources;
	assign sources = {i_rtc_irq & i_rtc_enable, i_ext_reset, i_wdt_irq, i_wdt_reset,
		i_twi_match, i_pin_change, i_irq};

	slpmc_wake_filter u_filter (
		.i_mode(mode_reg),
		.i_sources(sources),
		.o_wake(wake)
	);

	wire osc_stopped;
	assign osc_stopped = (mode_reg == `SLPMC_MODE_PDOWN) || (mode_reg == `SLPMC_MODE_PSAVE);

	always @* begin
		state_next = state_reg;
		case (state_reg)
			`SLPMC_ST_ACTIVE: begin
				if (i_sleep_req) begin
					state_next = `SLPMC_ST_SLEEP; // RULE_01
				end
			end
			`SLPMC_ST_SLEEP: begin
				if (wake && osc_stopped) begin
					state_next = `SLPMC_ST_WAKE; // RULE_12
				end else if (wake) begin
					state_next = `SLPMC_ST_ACTIVE; // RULE_02
				end
			end
			`SLPMC_ST_WAKE: begin
				if (i_clk_stable) begin
					state_next = `SLPMC_ST_ACTIVE; // RULE_12
				end
			end
			default: begin
				state_next = `SLPMC_ST_ACTIVE;
			end
		endcase
	end

	always @(posedge i_clock) begin
		if (!i_resetn) begin
			state_reg <= `SLPMC_ST_ACTIVE;
			mode_reg <= `SLPMC_MODE_IDLE;
		end else begin
			state_reg <= state_next;
			if (i_mode_we && valid_mode && state_reg == `SLPMC_ST_ACTIVE) begin
				mode_reg <= i_mode_wdata; // RULE_13
			end
		end
	end
	// ==========================================
	// Gate values per controller state and mode
	// Gates follow state_next, so they switch on the same edge as the state.
	// A mode written on the entry edge takes effect on the gates one edge later.
	reg gate_cpu_next;
	reg gate_nvm_next;
	reg gate_periph_next;
	reg gate_event_next;
	reg gate_osc_next;
	reg gate_rtc_next;
	reg sleeping_next;

	always @* begin
		gate_cpu_next = 1'b1;
		gate_nvm_next = 1'b1;
		gate_periph_next = 1'b1;
		gate_event_next = 1'b1;
		gate_osc_next = 1'b1;
		gate_rtc_next = i_rtc_enable;
		sleeping_next = 1'b0;
		case (state_next)
			`SLPMC_ST_ACTIVE: begin
				sleeping_next = 1'b0;
			end
			`SLPMC_ST_SLEEP: begin
				gate_cpu_next = 1'b0; // RULE_03
				gate_nvm_next = 1'b0; // RULE_03
				sleeping_next = 1'b1;
				case (mode_reg)
					`SLPMC_MODE_IDLE: begin
						gate_periph_next = 1'b1; // RULE_03
						gate_event_next = 1'b1; // RULE_11
						gate_osc_next = 1'b1;
						gate_rtc_next = i_rtc_enable;
					end
					`SLPMC_MODE_PDOWN: begin
						gate_periph_next = 1'b0; // RULE_05
						gate_event_next = 1'b0; // RULE_11
						gate_osc_next = 1'b0; // RULE_05
						gate_rtc_next = 1'b0;
					end
					`SLPMC_MODE_PSAVE: begin
						gate_periph_next = 1'b0;
						gate_event_next = 1'b0; // RULE_11
						gate_osc_next = 1'b0;
						gate_rtc_next = i_rtc_enable; // RULE_07
					end
					`SLPMC_MODE_STDBY: begin
						gate_periph_next = 1'b0;
						gate_event_next = 1'b0; // RULE_11
						gate_osc_next = 1'b1; // RULE_09
						gate_rtc_next = 1'b0;
					end
					`SLPMC_MODE_ESTDBY: begin
						gate_periph_next = 1'b0;
						gate_event_next = 1'b0; // RULE_11
						gate_osc_next = 1'b1; // RULE_10
						gate_rtc_next = i_rtc_enable; // RULE_10
					end
					default: begin
						gate_periph_next = 1'b0;
						gate_event_next = 1'b0;
						gate_osc_next = 1'b0;
						gate_rtc_next = 1'b0;
					end
				endcase
			end
			`SLPMC_ST_WAKE: begin
				// Oscillators restart; CPU held until the clock reports stable
				gate_cpu_next = 1'b0; // RULE_12
				gate_nvm_next = 1'b0; // RULE_12
				gate_periph_next = 1'b0;
				gate_event_next = 1'b0;
				gate_osc_next = 1'b1; // RULE_12
				gate_rtc_next = i_rtc_enable;
				sleeping_next = 1'b1;
			end
			default: begin
				sleeping_next = 1'b0;
			end
		endcase
	end

	// ==========================================
	// Output flops
	// Every gate comes straight from a flop to keep clock enables glitch free.
	always @(posedge i_clock) begin
		if (!i_resetn) begin
			o_cpu_run <= 1'b1;
			o_nvm_clk_en <= 1'b1;
			o_periph_clk_en <= 1'b1;
			o_event_clk_en <= 1'b1;
			o_osc_en <= 1'b1;
			o_rtc_clk_en <= 1'b0;
			o_sleeping <= 1'b0;
			o_mode <= `SLPMC_MODE_IDLE;
		end else begin
			o_cpu_run <= gate_cpu_next;
			o_nvm_clk_en <= gate_nvm_next;
			o_periph_clk_en <= gate_periph_next;
			o_event_clk_en <= gate_event_next;
			o_osc_en <= gate_osc_next;
			o_rtc_clk_en <= gate_rtc_next;
			o_sleeping <= sleeping_next;
			o_mode <= mode_reg;
		end
	end
endmodule // slpmc_top

// ==== rtl/slpmc_wake_filter.v ====
// Wake source qualification for the chosen sleep mode.
// Assumes wake inputs are synchronous level requests.
`include "slpmc_defs.vh"

module slpmc_wake_filter (
	input wire [2:0] i_mode,
	input wire [`SLPMC_WK_WIDTH-1:0] i_sources,
	output wire o_wake
);
	reg [`SLPMC_WK_WIDTH-1:0] allow;
	always @* begin
		allow = {`SLPMC_WK_WIDTH{1'b0}};
		case (i_mode)
			`SLPMC_MODE_IDLE: begin
				allow = {`SLPMC_WK_WIDTH{1'b1}}; // RULE_04
			end
			`SLPMC_MODE_PDOWN, `SLPMC_MODE_STDBY: begin
				allow[`SLPMC_WK_PINCHG] = 1'b1; // RULE_06
				allow[`SLPMC_WK_TWI_MATCH] = 1'b1;
				allow[`SLPMC_WK_WDT_RST] = 1'b1;
				allow[`SLPMC_WK_WDT_IRQ] = 1'b1;
				allow[`SLPMC_WK_EXT_RST] = 1'b1;
			end
			`SLPMC_MODE_PSAVE, `SLPMC_MODE_ESTDBY: begin
				allow[`SLPMC_WK_PINCHG] = 1'b1; // RULE_08
				allow[`SLPMC_WK_TWI_MATCH] = 1'b1;
				allow[`SLPMC_WK_WDT_RST] = 1'b1;
				allow[`SLPMC_WK_WDT_IRQ] = 1'b1;
				allow[`SLPMC_WK_EXT_RST] = 1'b1;
				allow[`SLPMC_WK_RTC_IRQ] = 1'b1; // RULE_10
			end
			default: begin
				allow = {`SLPMC_WK_WIDTH{1'b0}};
			end
		endcase
	end
	assign o_wake = |(allow & i_sources);
endmodule // slpmc_wake_filter

// ==== test/slpmc_assertions.sv ====
// Checker on the sleep mode controller top ports.
// Assumes binding to slpmc_top, everything on i_clock.
module slpmc_checker (
	input wire i_clock, i_resetn, i_sleep_req, i_irq, i_clk_stable, i_rtc_enable,
	input wire o_cpu_run, o_nvm_clk_en, o_periph_clk_en, o_event_clk_en,
	input wire o_osc_en, o_rtc_clk_en, o_sleeping,
	input wire [2:0] o_mode
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_resetn);
	nvm_cpu_a: assert property (o_nvm_clk_en == o_cpu_run) else $error("nvm");
	sleep_entry_a: assert property (!o_sleeping && i_sleep_req |=> o_sleeping)
		else $error("entry");
	cpu_halt_a: assert property (o_sleeping |-> !o_cpu_run) else $error("cpu");
	idle_wake_a: assert property (o_sleeping && o_mode == 3'h0 && i_irq |=> !o_sleeping)
		else $error("idle wake");
	deep_gate_a: assert property (!o_osc_en |-> !o_periph_clk_en && !o_event_clk_en)
		else $error("deep");
	osc_keep_a: assert property (o_sleeping && o_mode[2] |-> o_osc_en) else $error("osc");
	event_off_a: assert property (o_sleeping && o_mode[2] |-> !o_event_clk_en)
		else $error("event");
	clock_hold_a: assert property (o_sleeping && !o_osc_en |=> !o_cpu_run) else $error("hold");
	rtc_gate_a: assert property (!i_rtc_enable |=> !o_rtc_clk_en) else $error("rtc");
	cover property (o_sleeping && !o_osc_en);
	cover property (o_sleeping && o_mode[2]);
	cover property ($fell(o_sleeping));
endmodule // slpmc_checker
bind slpmc_top slpmc_checker slpmc_checker_i (.*);

// ==== test/slpmc_top_tb.sv ====
// Self-checking bench for the sleep mode controller.
// Assumes slpmc_top and its header on the include path.
module slpmc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rstn = 0, we = 0, req = 0, rtc_en = 0, stable = 0;
	logic [2:0] wd = 3'h0;
	logic [6:0] w = 7'h00;
	wire cpu, nvm, per, evt, osc, rtc, slp;
	wire [2:0] mode;
	wire [6:0] st = {cpu, nvm, per, evt, osc, rtc, slp};
	int errors = 0, check_count = 0;
	slpmc_top slpmc_top_i (.i_clock(clk), .i_resetn(rstn), .i_mode_we(we), .i_mode_wdata(wd),
		.i_sleep_req(req), .i_rtc_enable(rtc_en), .i_clk_stable(stable), .i_irq(w[0]),
		.i_pin_change(w[1]), .i_twi_match(w[2]), .i_wdt_reset(w[3]), .i_wdt_irq(w[4]),
		.i_ext_reset(w[5]), .i_rtc_irq(w[6]), .o_cpu_run(cpu), .o_nvm_clk_en(nvm),
		.o_periph_clk_en(per), .o_event_clk_en(evt), .o_osc_en(osc), .o_rtc_clk_en(rtc),
		.o_sleeping(slp), .o_mode(mode));
	initial forever #20 clk = ~clk;
	task cyc(); @(posedge clk); #1; endtask
	task chk(string n, logic [9:0] s, logic [9:0] e);
		check_count++;
		if (s !== e) begin errors++; $display("BAD %s exp %h seen %h", n, e, s); end
	endtask
	task go(logic [2:0] m);
		wd = m; we = 1; cyc(); we = 0; req = 1; cyc(); req = 0;
		chk("mode", mode, m);
	endtask
	task wake(logic [6:0] v); w = v; cyc(); w = 7'h00; endtask
	task idle_case();
		go(3'h0); chk("idle", st, 7'b0011101);
		wake(7'h01); chk("idle wake", st, 7'b1111100);
	endtask
	task pdown_case();
		for (int i = 1; i < 6; i++) begin
			go(3'h2); chk("pdown", st, 7'b0000001);
			wake(7'h01 << i); chk("wait", {cpu, osc, slp}, 3'b011);
			cyc(); chk("held", {cpu, slp}, 2'b01);
			stable = 1; cyc(); stable = 0; chk("up", {cpu, slp}, 2'b10);
		end
		go(3'h2); wake(7'h41); chk("refuse", st, 7'b0000001);
		wake(7'h02); stable = 1; cyc(); stable = 0; chk("up", {cpu, slp}, 2'b10);
	endtask
	task save_case();
		go(3'h3); chk("psave", st, 7'b0000011);
		wake(7'h40); chk("wait", {cpu, osc, slp}, 3'b011);
		stable = 1; cyc(); stable = 0; chk("up", {cpu, slp}, 2'b10);
	endtask
	task standby_case();
		go(3'h6); chk("stdby", st, 7'b0000101);
		wd = 3'h0; we = 1; cyc(); we = 0; chk("locked", mode, 3'h6);
		wake(7'h01); chk("ignored", slp, 1'b1);
		wake(7'h04); chk("fast", {cpu, slp}, 2'b10);
		go(3'h7); chk("estdby", st, 7'b0000111);
		wake(7'h40); chk("fast", {cpu, slp}, 2'b10);
		wd = 3'h5; we = 1; cyc(); we = 0; chk("illegal", mode, 3'h7);
	endtask
	task conclude();
		if (errors == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (5) cyc();
		chk("reset", {st, mode}, 10'b1111100000);
		rstn = 1;
		idle_case();
		rtc_en = 1;
		pdown_case();
		save_case();
		standby_case();
		conclude();
	end
endmodule // slpmc_top_tb
